// *** rtl/pmac_cfg.svh ***
// constants for the power monitor alert and compensation core
// assumes one 100 MHz clock and a 32-bit apb register port
`ifndef PMAC_CFG_SVH
`define PMAC_CFG_SVH
// register byte offsets
`define PMAC_OFS_CONFIG 8'h00
`define PMAC_OFS_ADC_CONFIG 8'h04
`define PMAC_OFS_SHUNT_NOM 8'h08
`define PMAC_OFS_SHUNT_COEFF 8'h0C
`define PMAC_OFS_DIE_TEMP 8'h10
`define PMAC_OFS_CURRENT 8'h14
`define PMAC_OFS_POWER 8'h18
`define PMAC_OFS_DIAG 8'h1C
`define PMAC_OFS_SHUNT_HIGH 8'h20
`define PMAC_OFS_SHUNT_LOW 8'h24
`define PMAC_OFS_RAIL_HIGH 8'h28
`define PMAC_OFS_RAIL_LOW 8'h2C
`define PMAC_OFS_HEAT_LIMIT 8'h30
`define PMAC_OFS_WATT_LIMIT 8'h34
// field positions
`define PMAC_CFG_TCOMP_BIT 0
`define PMAC_COEFF_MSB 13
`define PMAC_D_LATCH 15
`define PMAC_D_RDY_EN 14
`define PMAC_D_AVG_CMP 13
`define PMAC_D_POL 12
`define PMAC_D_MATH 10
`define PMAC_D_ENERGY 9
`define PMAC_D_CHARGE 8
`define PMAC_D_HEAT 7
`define PMAC_D_SH_OVER 6
`define PMAC_D_SH_UNDER 5
`define PMAC_D_RAIL_OVER 4
`define PMAC_D_RAIL_UNDER 3
`define PMAC_D_WATT 2
`define PMAC_D_DONE 1
`define PMAC_D_TRIM 0
// mode codes
`define PMAC_MODE_SHUT 2'h0
`define PMAC_MODE_TRIG 2'h1
`define PMAC_MODE_CONT 2'h2
// reset values
`define PMAC_RST_SHUNT_LOW 16'h8000
`define PMAC_RST_SHUNT_HIGH 16'h7FFF
`define PMAC_RST_RAIL_HIGH 16'h7FFF
`define PMAC_RST_RAIL_LOW 16'h0000
`define PMAC_RST_HEAT_LIMIT 16'hFFFF
`define PMAC_RST_WATT_LIMIT 16'h7FFF
`define PMAC_RST_SHUNT_NOM 16'h1000
// compensation arithmetic
`define PMAC_REF_TEMP 17'sd25
`define PMAC_PPM_DIV 48'sd1000000
`define PMAC_COEFF_FULL_PPM 16384
`endif

// *** rtl/pmac_pkg.sv ***
// types for the power monitor alert and compensation core
// assumes pmac_cfg.svh supplies all numeric constants
package pmac_pkg;
    // conversion sequencer state, one-hot
    typedef enum logic [2:0] {
        PMAC_ST_SHUT = 3'b001,
        PMAC_ST_TRIG = 3'b010,
        PMAC_ST_CONT = 3'b100
    } pmac_state_t;
endpackage

// *** rtl/pmac_core.sv ***
// power monitor digital core: drift compensation, limits, alert, modes
// assumes an apb master on i_clk_sys and an adc front end on the same clock
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "pmac_cfg.svh"

// What this block does
// - compensate drift only when enable bit set
// - coefficient code counts ppm, full scale 16384
// - adjusted resistance from nominal, temperature, coefficient
// - coefficient always taken as positive
// - current recomputed from each die temperature
// - die temperature stored in readable register
// - system clock is the only time base
// - six limit checks set flags and alert
// - shunt limits reset to 8000h and 7FFFh
// - heat limit resets FFFFh, positive compare only
// - flag register shows causes and alert controls
// - latched alert holds until flag register read
// - ready alert optional, done flag always sets
// - averaged compare uses only final averaged results
// - open-drain alert low-active, polarity bit inverts
// - arithmetic overflow flag, never drives alert
// - trim memory flag reads one when good
// - separate energy and charge overflow flags
// - housekeeping flags never assert the alert
// - registers fully accessible in shutdown
// - shutdown held until run mode written
// - triggered run converts once, returns to shutdown
// - alert merges done events and limit events
// - done flag only after final averaged result
// - mode write aborts and restarts conversion
module pmac_core #(
    parameter int DATA_W = 16,
    parameter int ACC_W = 40
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // apb slave
    input wire logic [7:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // adc front end, same clock
    input wire logic i_sample_valid,
    input wire logic i_sample_final,
    input wire logic [DATA_W-1:0] i_shunt_sample,
    input wire logic [DATA_W-1:0] i_rail_sample,
    input wire logic [DATA_W-1:0] i_temp_sample,
    output logic o_conv_start,
    output logic [1:0] o_conv_mode,
    // trim memory status pin, asynchronous
    input wire logic i_trim_ok,
    // open-drain alert pin
    output logic o_alert_out,
    output logic o_alert_oe
);

    // apb decode
    wire setup_ph = i_psel & ~i_penable;
    wire access_ph = i_psel & i_penable;
    wire wr_acc = access_ph & i_pwrite;
    wire rd_acc = access_ph & ~i_pwrite;
    wire [15:0] wdat = i_pwdata[15:0];

    // one-hot select per register
    wire sel_cfg = (i_paddr == `PMAC_OFS_CONFIG);
    wire sel_adc = (i_paddr == `PMAC_OFS_ADC_CONFIG);
    wire sel_nom = (i_paddr == `PMAC_OFS_SHUNT_NOM);
    wire sel_coef = (i_paddr == `PMAC_OFS_SHUNT_COEFF);
    wire sel_temp = (i_paddr == `PMAC_OFS_DIE_TEMP);
    wire sel_cur = (i_paddr == `PMAC_OFS_CURRENT);
    wire sel_pwr = (i_paddr == `PMAC_OFS_POWER);
    wire sel_diag = (i_paddr == `PMAC_OFS_DIAG);
    wire sel_shh = (i_paddr == `PMAC_OFS_SHUNT_HIGH);
    wire sel_shl = (i_paddr == `PMAC_OFS_SHUNT_LOW);
    wire sel_rh = (i_paddr == `PMAC_OFS_RAIL_HIGH);
    wire sel_rl = (i_paddr == `PMAC_OFS_RAIL_LOW);
    wire sel_heat = (i_paddr == `PMAC_OFS_HEAT_LIMIT);
    wire sel_watt = (i_paddr == `PMAC_OFS_WATT_LIMIT);
    wire mapped = sel_cfg | sel_adc | sel_nom | sel_coef | sel_temp | sel_cur | sel_pwr | sel_diag
                | sel_shh | sel_shl | sel_rh | sel_rl | sel_heat | sel_watt;

    // software registers
    logic temp_comp_enable_r; // drift compensation on
    logic [15:0] shunt_nom_r; // nominal shunt resistance code
    logic [`PMAC_COEFF_MSB:0] shunt_coeff_reg_r; // ppm per degree
    logic [15:0] shunt_high_threshold_r;
    logic [15:0] shunt_low_threshold_r;
    logic [15:0] rail_high_threshold_r;
    logic [15:0] rail_low_threshold_r;
    logic [15:0] heat_threshold_r;
    logic [15:0] watt_threshold_r;
    logic alert_latch_enable_r;
    logic ready_alert_enable_r;
    logic averaged_compare_enable_r;
    logic alert_polarity_select_r;

    // results and flags
    logic [15:0] die_temperature_result_r;
    logic [15:0] current_r;
    logic [15:0] power_r;
    logic [5:0] limit_flags_r; // heat, sh over, sh under, rail over, rail under, watt
    logic conversion_done_flag_r;
    logic arith_overflow_flag_r;
    logic energy_accum_overflow_flag_r;
    logic charge_accum_overflow_flag_r;
    logic alert_hold_r; // latched alert state
    logic [ACC_W-1:0] energy_acc_r;
    logic [ACC_W-1:0] charge_acc_r;
    logic [31:0] prdata_r;
    logic conv_start_r;
    pmac_pkg::pmac_state_t state_r;
    pmac_pkg::pmac_state_t state_nxt;

    // trim status synchroniser
    logic trim_s1_r;
    logic trim_s2_r;

    // saturate a wide signed value to the data width
    function automatic logic [16:0] sat16(input logic signed [47:0] v);
        if (v > 48'sd32767) begin
            sat16 = {1'b1, 16'h7FFF};
        end else if (v < -48'sd32768) begin
            sat16 = {1'b1, 16'h8000};
        end else begin
            sat16 = {1'b0, v[15:0]};
        end
    endfunction

    // positive-only view: negative codes read as zero
    function automatic logic [15:0] pos_only(input logic [15:0] v);
        pos_only = v[15] ? 16'h0000 : v;
    endfunction

    // fresh temperature
    // new temperature from the current sample feeds the correction
    wire [15:0] temp_now = i_sample_valid ? i_temp_sample : die_temperature_result_r;

    // resistance adjust
    // delta from the 25 degree reference
    wire signed [16:0] t_delta = $signed({temp_now[15], temp_now}) - `PMAC_REF_TEMP;
    // positive coefficient
    // coefficient zero-extended, never sign-extended
    wire signed [47:0] coef_s = $signed({34'h0_0000_0000, shunt_coeff_reg_r});
    wire signed [47:0] nom_s = $signed({32'h0000_0000, shunt_nom_r});
    wire signed [47:0] drift = (nom_s * {{31{t_delta[16]}}, t_delta} * coef_s) / `PMAC_PPM_DIV;
    wire signed [47:0] r_adj = temp_comp_enable_r ? (nom_s + drift) : nom_s;
    wire r_bad = (r_adj <= 48'sd0);
    // current = shunt code * 2^15 / resistance
    wire signed [47:0] shunt_s = {{32{i_shunt_sample[15]}}, i_shunt_sample};
    wire signed [47:0] cur_wide = r_bad ? 48'sd0 : ((shunt_s <<< 15) / r_adj);
    wire [16:0] cur_sat = sat16(cur_wide);
    // power from current and rail, product shifted right by 15
    wire signed [47:0] pwr_wide = ($signed({{32{cur_sat[15]}}, cur_sat[15:0]})
                                 * $signed({32'h0000_0000, pos_only(i_rail_sample)})) >>> 15;
    wire [16:0] pwr_sat = sat16(pwr_wide);
    wire math_ovf = r_bad | cur_sat[16] | pwr_sat[16];

    // averaged compare
    // averaging: compare final results only
    wire cmp_en = i_sample_valid & (~averaged_compare_enable_r | i_sample_final);
    wire done_evt = i_sample_valid & i_sample_final;

    wire sh_over = $signed(i_shunt_sample) > $signed(shunt_high_threshold_r);
    wire sh_under = $signed(i_shunt_sample) < $signed(shunt_low_threshold_r);
    wire rail_over = pos_only(i_rail_sample) > rail_high_threshold_r;
    wire rail_under = pos_only(i_rail_sample) < rail_low_threshold_r;
    wire heat_over = ~i_temp_sample[15] & (i_temp_sample > heat_threshold_r);
    wire watt_over = $signed(pwr_sat[15:0]) > $signed(watt_threshold_r);
    wire [5:0] cmp_vec = {heat_over, sh_over, sh_under, rail_over, rail_under, watt_over};

    // diag read clears sticky state; set wins
    wire diag_rd = rd_acc & sel_diag;
    wire adc_wr = wr_acc & sel_adc;
    wire [1:0] mode_w = wdat[1:0];

    // latched flags
    // latch mode keeps flags until read
    wire [5:0] flags_keep = (alert_latch_enable_r & ~diag_rd) ? limit_flags_r : 6'h00;
    wire [5:0] flags_nxt = cmp_en ? (cmp_vec | flags_keep)
                                  : (alert_latch_enable_r ? flags_keep : limit_flags_r);

    // done flag
    // clears on read and on adc config write other than shutdown
    wire done_clr = diag_rd | (adc_wr & (mode_w != `PMAC_MODE_SHUT));
    wire done_nxt = done_evt | (conversion_done_flag_r & ~done_clr);

    wire alert_cause = (|flags_nxt) | (ready_alert_enable_r & done_nxt);
    wire alert_hold_nxt = alert_cause | (alert_latch_enable_r & alert_hold_r & ~diag_rd);

    // sample pacing
    // accumulators advance on final results in continuous mode only
    wire acc_en = done_evt & state_r[2];
    wire [ACC_W:0] energy_sum = {1'b0, energy_acc_r} + {{(ACC_W-15){1'b0}}, pos_only(pwr_sat[15:0])};
    wire [ACC_W:0] charge_sum = {1'b0, charge_acc_r} + {{(ACC_W-15){1'b0}}, pos_only(cur_sat[15:0])};

    wire [15:0] diag_view = {alert_latch_enable_r, ready_alert_enable_r, averaged_compare_enable_r,
                             alert_polarity_select_r, 1'b0, arith_overflow_flag_r,
                             energy_accum_overflow_flag_r, charge_accum_overflow_flag_r,
                             limit_flags_r, conversion_done_flag_r, trim_s2_r};

    // mode readback from the sequencer state
    wire [1:0] mode_now = state_r[2] ? `PMAC_MODE_CONT : (state_r[1] ? `PMAC_MODE_TRIG : `PMAC_MODE_SHUT);

    // access in any mode
    // read mux, no mode gating
    wire [15:0] rd_mux = sel_cfg ? {15'h0000, temp_comp_enable_r}
                       : sel_adc ? {14'h0000, mode_now}
                       : sel_nom ? shunt_nom_r
                       : sel_coef ? {2'b00, shunt_coeff_reg_r}
                       : sel_temp ? die_temperature_result_r
                       : sel_cur ? current_r
                       : sel_pwr ? power_r
                       : sel_diag ? diag_view
                       : sel_shh ? shunt_high_threshold_r
                       : sel_shl ? shunt_low_threshold_r
                       : sel_rh ? rail_high_threshold_r
                       : sel_rl ? rail_low_threshold_r
                       : sel_heat ? heat_threshold_r
                       : sel_watt ? watt_threshold_r
                       : 16'h0000;

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pmac_pkg::PMAC_ST_TRIG: begin
                if (done_evt) begin
                    state_nxt = pmac_pkg::PMAC_ST_SHUT;
                end
            end
            default: begin
                state_nxt = state_r;
            end
        endcase
        if (adc_wr) begin
            if (mode_w == `PMAC_MODE_TRIG) begin
                state_nxt = pmac_pkg::PMAC_ST_TRIG;
            end else if (mode_w == `PMAC_MODE_CONT) begin
                state_nxt = pmac_pkg::PMAC_ST_CONT;
            end else begin
                state_nxt = pmac_pkg::PMAC_ST_SHUT;
            end
        end
    end

    // sequencer state and restart strobe
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_r <= pmac_pkg::PMAC_ST_SHUT;
            conv_start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            conv_start_r <= adc_wr;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            trim_s1_r <= 1'b0;
            trim_s2_r <= 1'b0;
        end else begin
            trim_s1_r <= i_trim_ok;
            trim_s2_r <= trim_s1_r;
        end
    end

    // configuration and threshold writes
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            temp_comp_enable_r <= 1'b0;
            shunt_nom_r <= `PMAC_RST_SHUNT_NOM;
            shunt_coeff_reg_r <= '0;
            shunt_high_threshold_r <= `PMAC_RST_SHUNT_HIGH;
            shunt_low_threshold_r <= `PMAC_RST_SHUNT_LOW;
            rail_high_threshold_r <= `PMAC_RST_RAIL_HIGH;
            rail_low_threshold_r <= `PMAC_RST_RAIL_LOW;
            heat_threshold_r <= `PMAC_RST_HEAT_LIMIT;
            watt_threshold_r <= `PMAC_RST_WATT_LIMIT;
        end else if (wr_acc) begin
            if (sel_cfg) temp_comp_enable_r <= wdat[`PMAC_CFG_TCOMP_BIT];
            if (sel_coef) shunt_coeff_reg_r <= wdat[`PMAC_COEFF_MSB:0];
            if (sel_nom) shunt_nom_r <= wdat;
            if (sel_shh) shunt_high_threshold_r <= wdat;
            if (sel_shl) shunt_low_threshold_r <= wdat;
            if (sel_rh) rail_high_threshold_r <= wdat;
            if (sel_rl) rail_low_threshold_r <= wdat;
            if (sel_heat) heat_threshold_r <= wdat;
            if (sel_watt) watt_threshold_r <= wdat;
        end
    end

    // alert control bits in the flag register
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            alert_latch_enable_r <= 1'b0;
            ready_alert_enable_r <= 1'b0;
            averaged_compare_enable_r <= 1'b0;
            alert_polarity_select_r <= 1'b0;
        end else if (wr_acc & sel_diag) begin
            alert_latch_enable_r <= wdat[`PMAC_D_LATCH];
            ready_alert_enable_r <= wdat[`PMAC_D_RDY_EN];
            averaged_compare_enable_r <= wdat[`PMAC_D_AVG_CMP];
            alert_polarity_select_r <= wdat[`PMAC_D_POL];
        end
    end

    // measurement results
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            die_temperature_result_r <= 16'h0000;
            current_r <= 16'h0000;
            power_r <= 16'h0000;
        end else if (i_sample_valid) begin
            die_temperature_result_r <= i_temp_sample;
            current_r <= cur_sat[15:0];
            power_r <= pwr_sat[15:0];
        end
    end

    // flags and alert hold
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            limit_flags_r <= 6'h00;
            conversion_done_flag_r <= 1'b0;
            arith_overflow_flag_r <= 1'b0;
            energy_accum_overflow_flag_r <= 1'b0;
            charge_accum_overflow_flag_r <= 1'b0;
            alert_hold_r <= 1'b0;
        end else begin
            limit_flags_r <= flags_nxt;
            conversion_done_flag_r <= done_nxt;
            arith_overflow_flag_r <= (i_sample_valid & math_ovf) | (arith_overflow_flag_r & ~diag_rd);
            energy_accum_overflow_flag_r <= (acc_en & energy_sum[ACC_W])
                                          | (energy_accum_overflow_flag_r & ~diag_rd);
            charge_accum_overflow_flag_r <= (acc_en & charge_sum[ACC_W])
                                          | (charge_accum_overflow_flag_r & ~diag_rd);
            alert_hold_r <= alert_hold_nxt;
        end
    end

    // energy and charge accumulators
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            energy_acc_r <= '0;
            charge_acc_r <= '0;
        end else if (acc_en) begin
            energy_acc_r <= energy_sum[ACC_W-1:0];
            charge_acc_r <= charge_sum[ACC_W-1:0];
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_r <= {16'h0000, rd_mux};
        end
    end

    // apb answer: zero wait states, error on unmapped
    assign o_prdata = prdata_r;
    assign o_pready = access_ph;
    assign o_pslverr = access_ph & ~mapped;
    assign o_conv_start = conv_start_r;
    assign o_conv_mode = mode_now;
    // open-drain polarity
    // pin only ever pulled low; active-high idles low
    assign o_alert_out = 1'b0;
    assign o_alert_oe = alert_hold_r ^ alert_polarity_select_r;

endmodule // pmac_core

// *** bench/pmac_core_chk.sv ***
// checker for the apb port and the mode sequencer of pmac_core
// bound onto pmac_core, sees its ports
`timescale 1ns/10ps
`include "pmac_cfg.svh"
module pmac_core_chk (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_sample_valid,
    input wire logic i_sample_final,
    input wire logic o_conv_start,
    input wire logic [1:0] o_conv_mode
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // access phase writing the mode register
    wire logic mode_wr = i_psel && i_penable && i_pwrite && i_paddr == `PMAC_OFS_ADC_CONFIG;
    // final result arriving during a triggered run
    sequence s_final;
        i_sample_valid && i_sample_final;
    endsequence
    sequence s_trig_done;
        o_conv_mode == `PMAC_MODE_TRIG ##0 s_final;
    endsequence
    a_ready_zero_wait: assert property (o_pready == (i_psel && i_penable))
        else $error("pready not zero wait");
    a_error_in_access: assert property (o_pslverr |-> o_pready)
        else $error("pslverr outside access");
    a_unmapped_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_start_after_write: assert property (mode_wr |=> o_conv_start)
        else $error("no restart after mode write");
    a_start_single: assert property (o_conv_start |=> !o_conv_start)
        else $error("start pulse too long");
    a_shut_holds: assert property (o_conv_mode == `PMAC_MODE_SHUT && !mode_wr |=> o_conv_mode == `PMAC_MODE_SHUT)
        else $error("left shutdown unasked");
    a_trig_to_shut: assert property (s_trig_done ##0 !mode_wr |=> o_conv_mode == `PMAC_MODE_SHUT)
        else $error("triggered run did not stop");
endmodule // pmac_core_chk
bind pmac_core pmac_core_chk u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_paddr(i_paddr),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid),
    .i_sample_final(i_sample_final), .o_conv_start(o_conv_start), .o_conv_mode(o_conv_mode));

// *** bench/pmac_adc_model.sv ***
// model of the adc front end feeding pmac_core
// assumes the core's start pulse and mode output, same clock
`timescale 1ns/10ps
`include "pmac_cfg.svh"
module pmac_adc_model #(
    parameter int DLY = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_conv_start,
    input wire logic [1:0] i_conv_mode,
    input wire logic [15:0] i_shunt,
    input wire logic [15:0] i_rail,
    input wire logic [15:0] i_temp,
    output logic o_sample_valid,
    output logic [15:0] o_shunt,
    output logic [15:0] o_rail,
    output logic [15:0] o_temp
);
    int cnt_r; // cycles left to the result
    // one result per run, repeating only in continuous mode
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            cnt_r <= 0;
            o_sample_valid <= 1'b0;
            o_shunt <= 16'h0000;
            o_rail <= 16'h0000;
            o_temp <= 16'h0000;
        end else begin
            o_sample_valid <= 1'b0;
            // idle buses toggle
            o_shunt <= ~o_shunt;
            o_rail <= ~o_rail;
            o_temp <= ~o_temp;
            if (i_conv_start) begin
                // restart drops any result in flight
                cnt_r <= (i_conv_mode inside {`PMAC_MODE_TRIG, `PMAC_MODE_CONT}) ? DLY : 0;
            end else if (cnt_r == 1) begin
                o_sample_valid <= 1'b1;
                o_shunt <= i_shunt;
                o_rail <= i_rail;
                o_temp <= i_temp;
                cnt_r <= (i_conv_mode == `PMAC_MODE_CONT) ? DLY : 0;
            end else if (cnt_r > 1) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule // pmac_adc_model

// *** bench/testbench.sv ***
// self-checking bench for pmac_core with an adc front end model
// assumes a pulled-up alert line and apb reached through tasks
`timescale 1ns/10ps
`include "pmac_cfg.svh"
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] sh = 16'h0000;
    logic [15:0] te = 16'h0019;
    logic [15:0] ra = 16'h0100;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, valid, start, alert_out, alert_oe;
    logic [1:0] mode;
    logic [15:0] ms, mr, mt;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    // open-drain pin with its pull-up
    wire logic line = alert_oe ? alert_out : 1'b1;
    always #5 clk = ~clk;
    pmac_core u_pmac_core (.i_clk_sys(clk), .i_reset(reset), .i_paddr(paddr), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sample_valid(valid), .i_sample_final(valid),
        .i_shunt_sample(ms), .i_rail_sample(mr), .i_temp_sample(mt), .o_conv_start(start),
        .o_conv_mode(mode), .i_trim_ok(1'b1), .o_alert_out(alert_out), .o_alert_oe(alert_oe));
    pmac_adc_model u_pmac_adc_model (.i_clk_sys(clk), .i_reset(reset), .i_conv_start(start),
        .i_conv_mode(mode), .i_shunt(sh), .i_rail(ra), .i_temp(te), .o_sample_valid(valid),
        .o_shunt(ms), .o_rail(mr), .o_temp(mt));
    // verdict and end of run
    task automatic wrap_up;
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // triggered run to shutdown
    task automatic conv(input logic [15:0] s);
        sh <= s;
        apb(`PMAC_OFS_ADC_CONFIG, 1'b1, 32'h0000_0001);
        while (mode !== `PMAC_MODE_SHUT) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    // expected current
    function automatic logic [15:0] exp_cur(input logic [15:0] s, input logic [15:0] t,
        input logic [15:0] co, input logic en);
        longint r;
        longint q;
        r = 4096;
        if (en) r = r + 4096 * (longint'($signed(t)) - 25) * longint'(co) / 1000000;
        q = longint'($signed(s)) * 32768 / r;
        if (q > 32767) q = 32767;
        if (q < -32768) q = -32768;
        return q[15:0];
    endfunction
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up;
        end
    end
    initial begin
        logic [7:0] ofs [9] = '{`PMAC_OFS_SHUNT_HIGH, `PMAC_OFS_SHUNT_LOW, `PMAC_OFS_RAIL_HIGH,
            `PMAC_OFS_RAIL_LOW, `PMAC_OFS_HEAT_LIMIT, `PMAC_OFS_WATT_LIMIT, `PMAC_OFS_SHUNT_NOM,
            `PMAC_OFS_SHUNT_COEFF, `PMAC_OFS_CONFIG};
        logic [15:0] rv [9] = '{16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000,
            16'hFFFF, 16'h7FFF, 16'h1000, 16'h0000, 16'h0000};
        logic [15:0] hi, lo, co, s, t;
        logic en, ov, un;
        void'($urandom(7039));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (ofs[i]) begin
            apb(ofs[i], 1'b0, 32'h0000_0000);
            chk("reset value", rd, 32'(rv[i]));
        end
        apb(`PMAC_OFS_DIAG, 1'b0, 32'h0000_0000);
        chk("diag after reset", rd & 32'h0000_FF7F, 32'h0000_0001);
        chk("alert idle", line, 1'b1);
        apb(8'h3C, 1'b0, 32'h0000_0000);
        chk("unmapped data", rd, 32'h0000_0000);
        chk("unmapped error", err, 1'b1);
        apb(`PMAC_OFS_HEAT_LIMIT, 1'b1, 32'h0000_7FFF);
        // random cases, boundaries first
        for (int i = 0; i < 8; i++) begin
            en = $urandom_range(0, 1);
            co = $urandom_range(0, 16383);
            hi = $urandom_range(0, 2000);
            lo = 16'(-int'($urandom_range(0, 2000)));
            s = 16'(int'($urandom_range(0, 4000)) - 2000);
            t = $urandom_range(0, 125);
            if (i == 0) s = hi;
            if (i == 1) s = hi + 16'h0001;
            if (i == 2) s = lo;
            if (i == 3) s = lo - 16'h0001;
            ov = $signed(s) > $signed(hi);
            un = $signed(s) < $signed(lo);
            te <= t;
            apb(`PMAC_OFS_CONFIG, 1'b1, 32'(en));
            apb(`PMAC_OFS_SHUNT_COEFF, 1'b1, 32'(co));
            apb(`PMAC_OFS_SHUNT_HIGH, 1'b1, 32'(hi));
            apb(`PMAC_OFS_SHUNT_LOW, 1'b1, 32'(lo));
            conv(s);
            chk("alert line", line, !(ov || un));
            apb(`PMAC_OFS_CURRENT, 1'b0, 32'h0000_0000);
            chk("current", rd, 32'(exp_cur(s, t, co, en)));
            apb(`PMAC_OFS_DIE_TEMP, 1'b0, 32'h0000_0000);
            chk("temperature", rd, 32'(t));
            apb(`PMAC_OFS_DIAG, 1'b0, 32'h0000_0000);
            chk("flags", rd & 32'h0000_047F, (32'(ov) << 6) | (32'(un) << 5) | 32'h0000_0003);
        end
        apb(`PMAC_OFS_RAIL_HIGH, 1'b1, 32'h0000_1234);
        apb(`PMAC_OFS_RAIL_HIGH, 1'b0, 32'h0000_0000);
        chk("shutdown access", rd, 32'h0000_1234);
        // latched alert survives a clean sample
        apb(`PMAC_OFS_DIAG, 1'b1, 32'h0000_8000);
        conv(16'h0FA0);
        chk("alert raised", line, 1'b0);
        conv(16'h0000);
        chk("latch holds", line, 1'b0);
        apb(`PMAC_OFS_DIAG, 1'b0, 32'h0000_0000);
        chk("latched cause", rd[6], 1'b1);
        repeat (3) @(posedge clk);
        chk("latch cleared", line, 1'b1);
        // ready alert with high polarity
        apb(`PMAC_OFS_DIAG, 1'b1, 32'h0000_5000);
        repeat (2) @(posedge clk);
        chk("high polarity idle", line, 1'b0);
        conv(16'h0000);
        chk("ready alert", line, 1'b1);
        apb(`PMAC_OFS_DIAG, 1'b0, 32'h0000_0000);
        chk("done flag", rd[1], 1'b1);
        apb(`PMAC_OFS_ADC_CONFIG, 1'b1, 32'h0000_0002);
        repeat (20) @(posedge clk);
        chk("continuous mode", mode, `PMAC_MODE_CONT);
        apb(`PMAC_OFS_ADC_CONFIG, 1'b1, 32'h0000_0000);
        chk("shutdown mode", mode, `PMAC_MODE_SHUT);
        wrap_up;
    end
endmodule // testbench
